// *** hdl/snp_pkg.sv ***
// snp_pkg: shared constants and carrier types for the serial nor interface and protection block.
// assumes a 40 MHz core clock; the serial clock is a separate domain.
package snp_pkg;

  localparam int CORE_CLK_MHZ        = 40;
  localparam int PUW_TIME_US_DEFAULT = 1000;

  // instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE      = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE     = 8'h04;
  localparam logic [7:0] OP_WRITE_STATUS      = 8'h01;
  localparam logic [7:0] OP_READ_STATUS_LO    = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_HI    = 8'h35;
  localparam logic [7:0] OP_PAGE_PROGRAM      = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE      = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE_32K   = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE_64K   = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A      = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B      = 8'h60;
  localparam logic [7:0] OP_SEC_REG_ERASE     = 8'h44;
  localparam logic [7:0] OP_SEC_REG_PROGRAM   = 8'h42;
  localparam logic [7:0] OP_SUSPEND           = 8'h75;
  localparam logic [7:0] OP_POWER_DOWN        = 8'hb9;
  localparam logic [7:0] OP_RELEASE_PD        = 8'hab;
  localparam logic [7:0] OP_FAST_DUAL_OUT     = 8'h3b;
  localparam logic [7:0] OP_FAST_DUAL_IO      = 8'hbb;
  localparam logic [7:0] OP_FAST_QUAD_OUT     = 8'h6b;
  localparam logic [7:0] OP_FAST_QUAD_IO      = 8'heb;
  localparam logic [7:0] OP_WORD_QUAD_IO      = 8'he7;

  // frame lengths in whole bytes
  localparam logic [7:0] LEN_ZERO     = 8'h00;
  localparam logic [7:0] LEN_CMD      = 8'h01;
  localparam logic [7:0] LEN_SR_ONE   = 8'h02;
  localparam logic [7:0] LEN_SR_TWO   = 8'h03;
  localparam logic [7:0] LEN_ADDR_CMD = 8'h04;
  localparam logic [7:0] LEN_PROG_MIN = 8'h05;
  localparam logic [7:0] LEN_MAX      = 8'hff;
  localparam logic [7:0] BYTE_OP      = 8'h00;
  localparam logic [7:0] BYTE_D1      = 8'h01;
  localparam logic [7:0] BYTE_D2      = 8'h02;

  // serial clock counts in a frame; output starts once this many rising edges have passed
  localparam logic [6:0] CYC_ONE          = 7'h01;
  localparam logic [6:0] CYC_MAX          = 7'h7f;
  localparam logic [6:0] OUT_AT_STATUS    = 7'h08;
  localparam logic [6:0] OUT_AT_DUAL_OUT  = 7'h28;
  localparam logic [6:0] OUT_AT_DUAL_IO   = 7'h18;
  localparam logic [6:0] OUT_AT_QUAD_OUT  = 7'h28;
  localparam logic [6:0] OUT_AT_QUAD_IO   = 7'h14;
  localparam logic [6:0] OUT_AT_WORD_QUAD = 7'h12;

  localparam logic [2:0] BIT_ZERO   = 3'h0;
  localparam logic [2:0] BIT_FIRST  = 3'h1;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [2:0] CNT_SINGLE = 3'h7;
  localparam logic [2:0] CNT_DUAL   = 3'h3;
  localparam logic [2:0] CNT_QUAD   = 3'h1;

  localparam logic [1:0] LOCK_SOFT  = 2'h0;
  localparam logic [1:0] LOCK_PIN   = 2'h1;
  localparam logic [1:0] LOCK_POWER = 2'h2;

  localparam logic [31:0] PU_ZERO = 32'h0000_0000;
  localparam logic [31:0] PU_ONE  = 32'h0000_0001;

  typedef enum logic [1:0] {LM_SINGLE, LM_DUAL, LM_QUAD} snp_lane_mode_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_STATUS_LO, SRC_STATUS_HI, SRC_ARRAY} snp_src_t;

  // bit 15 down to bit 0 of the two status bytes
  typedef struct packed {
    logic       suspend;
    logic       complement_protect;
    logic [3:0] sec_reg_lock;
    logic       four_lane_enable;
    logic       status_lock_sel_high;
    logic       status_lock_sel_low;
    logic       small_unit_protect;
    logic       bottom_select;
    logic [2:0] block_protect;
    logic       write_permit_latch;
    logic       busy;
  } snp_status_t;

  localparam int          STATUS_W     = $bits(snp_status_t);
  localparam snp_status_t STATUS_RESET = '0;

  typedef struct packed {
    logic       complement_protect;
    logic       small_unit_protect;
    logic       bottom_select;
    logic [2:0] block_protect;
  } snp_prot_t;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] bytes;
    logic       whole;
  } snp_frame_t;

endpackage

// *** hdl/snp_serial_nor_protect.sv ***
// snp_serial_nor_protect: serial interface front end and write protection of a serial nor flash.
// assumes an array engine on core_clk (eng_start/eng_done) and read data on rd_data in the sclk domain.
//
// Functional notes
// - single lane: instruction, address and data sampled from lane 0 on rising clock.
// - single lane: read or status data changes on lane 1 at falling clock.
// - only modes 0 and 3; clock idles low or high around select edges.
// - dual fast reads turn lanes 0 and 1 into bidirectional data lanes.
// - quad reads use four lanes; guard pin is lane 2, pause pin lane 3.
// - quad instructions accepted only with the four lane enable bit set.
// - pause works in single and dual operation with select low, never in quad.
// - pause starts at pin fall if clock low, else after next falling clock.
// - pause ends at pin rise if clock low, else after next falling clock.
// - paused: output floats, input and clock ignored, instruction state kept.
// - after power good, write enable, program, erase, status write refused until delay.
// - write permit latch zero at power up; write enable needed before writes.
// - latch set by write enable, cleared by write disable or write completion.
// - after power down only release power down is obeyed.
// - status write gated by lock select, write permit latch, guard pin outside quad.
// - busy reads one during writes; only status read and suspend accepted.
// - three block protect bits set protected amount, written by status write, default zero.
// - bottom select picks top when zero, bottom when one; default zero.
// - lock select: 00 soft, 01 guard pin low locks, 10 until power cycle, 11 forever.
`timescale 1ns/1ps
`default_nettype none
module snp_serial_nor_protect #(
  parameter int PUW_TIME_US = snp_pkg::PUW_TIME_US_DEFAULT,
  parameter int PUW_CYCLES  = PUW_TIME_US * snp_pkg::CORE_CLK_MHZ
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          power_good,
  input  wire logic          sclk,
  input  wire logic          cs_n,
  input  wire logic          lane_0_in,
  output logic               lane_0_out,
  output logic               lane_0_oe,
  input  wire logic          lane_1_in,
  output logic               lane_1_out,
  output logic               lane_1_oe,
  input  wire logic          lane_2_in,
  output logic               lane_2_out,
  output logic               lane_2_oe,
  input  wire logic          lane_3_in,
  output logic               lane_3_out,
  output logic               lane_3_oe,
  input  wire logic [7:0]    rd_data,
  output logic               rd_load,
  input  wire logic          eng_done,
  output logic               eng_start,
  output logic [7:0]         eng_op,
  output snp_pkg::snp_prot_t prot_cfg,
  output snp_pkg::snp_status_t status_word
);
  import snp_pkg::*;

  localparam logic [31:0] PUW_LIMIT = 32'(PUW_CYCLES);

  // core side state
  snp_status_t    status_reg;
  snp_status_t    status_next;
  logic           pd_reg;
  logic           pd_next;
  logic           cs_prev_reg;
  logic [31:0]    pu_cnt_reg;
  logic [31:0]    pu_cnt_next;
  logic           eng_start_reg;
  logic [7:0]     eng_op_reg;
  logic [2:0]     core_s;
  logic           cs_s;
  logic           pg_s;
  logic           wp_s;

  // link side state
  logic [STATUS_W:0] link_s;
  snp_status_t    status_link;
  logic           pd_link;
  logic           quad_sel;
  logic           pause_now;
  logic           started_reg;
  logic [6:0]     cyc_reg;
  logic [6:0]     cyc_next;
  logic [2:0]     bitc_reg;
  logic [2:0]     bitc_next;
  logic [7:0]     shift_reg;
  logic [7:0]     shift_next;
  logic [7:0]     bytes_reg;
  logic [7:0]     bytes_next;
  logic           byte_done;
  logic           first_done;
  logic [7:0]     op_reg;
  logic [7:0]     d1_reg;
  logic [7:0]     d2_reg;
  snp_lane_mode_t mode_reg;
  snp_lane_mode_t mode_next;
  snp_lane_mode_t dec_mode;
  snp_src_t       src_reg;
  snp_src_t       src_next;
  snp_src_t       dec_src;
  logic [6:0]     out_at_reg;
  logic [6:0]     dec_at;
  logic [7:0]     out_sh_reg;
  logic [2:0]     out_cnt_reg;
  logic           out_active;
  logic           load_now;
  logic [7:0]     src_byte;
  logic [7:0]     cur_word;
  logic [7:0]     word_next;
  logic [2:0]     cnt_reload;
  logic [3:0]     lane_val;
  logic [3:0]     lane_en;

  // status bits are independent flags; per-bit sync is enough for reads
  snp_sync_2ff #(.WIDTH(STATUS_W + 1)) u_link_sync (
    .clk (sclk),
    .d   ({pd_reg, status_reg}),
    .q   (link_s)
  );
  assign pd_link     = link_s[STATUS_W];
  assign status_link = snp_status_t'(link_s[STATUS_W-1:0]);
  assign quad_sel    = status_link.four_lane_enable;

  // pin level at each clock edge decides; a change in the high phase acts from the next fall
  // pause pin is lane 3 in quad, so pausing is off then
  assign pause_now = ~cs_n & ~quad_sel & ~lane_3_in;

  // frame counters; only edges inside a frame are counted, so idle clock level is irrelevant
  assign cyc_next   = ~started_reg ? CYC_ONE : ((cyc_reg == CYC_MAX) ? cyc_reg : cyc_reg + CYC_ONE);
  assign bitc_next  = started_reg ? bitc_reg + BIT_FIRST : BIT_FIRST;
  assign shift_next = {shift_reg[6:0], lane_0_in};
  assign byte_done  = started_reg & (bitc_reg == BIT_LAST);
  assign first_done = byte_done & (bytes_reg == BYTE_OP);
  assign bytes_next = ~started_reg ? LEN_ZERO :
                      (byte_done & (bytes_reg != LEN_MAX)) ? bytes_reg + LEN_CMD : bytes_reg;
  assign mode_next  = ~started_reg ? LM_SINGLE : (first_done ? dec_mode : mode_reg);
  assign src_next   = ~started_reg ? SRC_NONE : (first_done ? dec_src : src_reg);

  always_comb begin
    dec_mode = LM_SINGLE;
    dec_src  = SRC_NONE;
    dec_at   = OUT_AT_STATUS;
    case (shift_next)
      OP_READ_STATUS_LO: dec_src = SRC_STATUS_LO;
      OP_READ_STATUS_HI: dec_src = SRC_STATUS_HI;
      OP_FAST_DUAL_OUT: begin
        dec_mode = LM_DUAL;
        dec_src  = SRC_ARRAY;
        dec_at   = OUT_AT_DUAL_OUT;
      end
      OP_FAST_DUAL_IO: begin
        dec_mode = LM_DUAL;
        dec_src  = SRC_ARRAY;
        dec_at   = OUT_AT_DUAL_IO;
      end
      OP_FAST_QUAD_OUT: begin
        dec_mode = LM_QUAD;
        dec_src  = quad_sel ? SRC_ARRAY : SRC_NONE;
        dec_at   = OUT_AT_QUAD_OUT;
      end
      OP_FAST_QUAD_IO: begin
        dec_mode = LM_QUAD;
        dec_src  = quad_sel ? SRC_ARRAY : SRC_NONE;
        dec_at   = OUT_AT_QUAD_IO;
      end
      OP_WORD_QUAD_IO: begin
        dec_mode = LM_QUAD;
        dec_src  = quad_sel ? SRC_ARRAY : SRC_NONE;
        dec_at   = OUT_AT_WORD_QUAD;
      end
      default: dec_src = SRC_NONE;
    endcase
    // powered down: nothing answers; busy: only status reads answer
    if (pd_link) begin
      dec_src = SRC_NONE;
    end else if (status_link.busy && (dec_src == SRC_ARRAY)) begin
      dec_src = SRC_NONE;
    end
  end

  // select high clears the start flag; a master that lifts it mid-pause loses the instruction
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      started_reg <= 1'b0;
    end else if (!pause_now) begin
      started_reg <= 1'b1;
    end
  end

  // no reset: these must survive select high so the core can read the finished frame
  always_ff @(posedge sclk) begin
    if (!pause_now) begin
      cyc_reg    <= cyc_next;
      bitc_reg   <= bitc_next;
      shift_reg  <= shift_next;
      bytes_reg  <= bytes_next;
      mode_reg   <= mode_next;
      src_reg    <= src_next;
      out_at_reg <= first_done ? dec_at : out_at_reg;
      op_reg     <= first_done ? shift_next : op_reg;
      d1_reg     <= (byte_done && bytes_reg == BYTE_D1) ? shift_next : d1_reg;
      d2_reg     <= (byte_done && bytes_reg == BYTE_D2) ? shift_next : d2_reg;
    end
  end

  // output path, falling edge of the serial clock
  // mode 3 opens with a fall before any rise; stale frame state must not drive then
  assign out_active = started_reg & (src_reg != SRC_NONE) & (cyc_reg >= out_at_reg) & ~pause_now;
  assign load_now   = (out_cnt_reg == BIT_ZERO);
  assign src_byte   = (src_reg == SRC_STATUS_LO) ? status_link[7:0] :
                      (src_reg == SRC_STATUS_HI) ? status_link[15:8] : rd_data;
  assign cur_word   = load_now ? src_byte : out_sh_reg;

  always_comb begin
    case (mode_reg)
      LM_DUAL: begin
        lane_val   = {2'b00, cur_word[7], cur_word[6]};
        lane_en    = 4'b0011;
        word_next  = {cur_word[5:0], 2'b00};
        cnt_reload = CNT_DUAL;
      end
      LM_QUAD: begin
        lane_val   = cur_word[7:4];
        lane_en    = 4'b1111;
        word_next  = {cur_word[3:0], 4'b0000};
        cnt_reload = CNT_QUAD;
      end
      default: begin
        lane_val   = {2'b00, cur_word[7], 1'b0};
        lane_en    = 4'b0010;
        word_next  = {cur_word[6:0], 1'b0};
        cnt_reload = CNT_SINGLE;
      end
    endcase
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      {lane_3_out, lane_2_out, lane_1_out, lane_0_out} <= 4'b0000;
      {lane_3_oe, lane_2_oe, lane_1_oe, lane_0_oe}     <= 4'b0000;
      out_sh_reg  <= 8'h00;
      out_cnt_reg <= BIT_ZERO;
      rd_load     <= 1'b0;
    end else if (out_active) begin
      {lane_3_out, lane_2_out, lane_1_out, lane_0_out} <= lane_val;
      {lane_3_oe, lane_2_oe, lane_1_oe, lane_0_oe}     <= lane_en;
      out_sh_reg  <= word_next;
      out_cnt_reg <= load_now ? cnt_reload : out_cnt_reg - BIT_FIRST;
      rd_load     <= load_now & (src_reg == SRC_ARRAY);
    end else begin
      // float while paused or idle; shifter and count held for resume
      {lane_3_oe, lane_2_oe, lane_1_oe, lane_0_oe} <= 4'b0000;
      rd_load <= 1'b0;
    end
  end

  // core side: synchronised select, power good and guard pin
  snp_sync_2ff #(.WIDTH(3)) u_core_sync (
    .clk (core_clk),
    .d   ({cs_n, power_good, lane_2_in}),
    .q   (core_s)
  );
  assign cs_s = core_s[2];
  assign pg_s = core_s[1];
  assign wp_s = core_s[0];

  // link frame registers are still while select is high, so synced select qualifies them
  snp_frame_t frame_w;
  logic       frame_end;
  logic       accept;
  logic       write_ok;
  logic       wpl;
  logic       sr_unlocked;
  logic       len_cmd;
  logic       is_wren;
  logic       is_wrdi;
  logic       is_wrsr;
  logic       is_prog;
  logic       is_erase;
  logic       is_susp;
  logic       is_pd;
  logic       is_rpd;
  logic       work_start;
  logic       work_done;
  snp_status_t sr_new;

  assign frame_w   = '{op: op_reg, d1: d1_reg, d2: d2_reg, bytes: bytes_reg, whole: (bitc_reg == BIT_ZERO)};
  assign frame_end = cs_s & ~cs_prev_reg & pg_s & frame_w.whole;
  assign accept    = frame_end & (~pd_reg | (frame_w.op == OP_RELEASE_PD)) &
                     (~status_reg.busy | (frame_w.op == OP_SUSPEND));
  assign pu_cnt_next = ~pg_s ? PU_ZERO : ((pu_cnt_reg == PUW_LIMIT) ? pu_cnt_reg : pu_cnt_reg + PU_ONE);
  assign write_ok  = (pu_cnt_reg == PUW_LIMIT);
  assign wpl       = status_reg.write_permit_latch;
  assign len_cmd   = (frame_w.bytes == LEN_CMD);
  assign sr_unlocked = ({status_reg.status_lock_sel_high, status_reg.status_lock_sel_low} == LOCK_SOFT) |
                       (({status_reg.status_lock_sel_high, status_reg.status_lock_sel_low} == LOCK_PIN) &
                        (status_reg.four_lane_enable | wp_s));
  assign is_wren   = accept & (frame_w.op == OP_WRITE_ENABLE) & len_cmd & write_ok;
  assign is_wrdi   = accept & (frame_w.op == OP_WRITE_DISABLE) & len_cmd;
  assign is_wrsr   = accept & (frame_w.op == OP_WRITE_STATUS) & wpl & write_ok & sr_unlocked &
                     ((frame_w.bytes == LEN_SR_ONE) | (frame_w.bytes == LEN_SR_TWO));
  assign is_prog   = accept & wpl & write_ok & (frame_w.bytes >= LEN_PROG_MIN) &
                     ((frame_w.op == OP_PAGE_PROGRAM) | (frame_w.op == OP_SEC_REG_PROGRAM) |
                      ((frame_w.op == OP_QUAD_PAGE_PROGRAM) & status_reg.four_lane_enable));
  assign is_erase  = accept & wpl & write_ok &
                     ((((frame_w.op == OP_SECTOR_ERASE) | (frame_w.op == OP_BLOCK_ERASE_32K) |
                        (frame_w.op == OP_BLOCK_ERASE_64K) | (frame_w.op == OP_SEC_REG_ERASE)) &
                       (frame_w.bytes == LEN_ADDR_CMD)) |
                      (((frame_w.op == OP_CHIP_ERASE_A) | (frame_w.op == OP_CHIP_ERASE_B)) & len_cmd));
  assign is_susp   = accept & status_reg.busy & (frame_w.op == OP_SUSPEND) & len_cmd;
  assign is_pd     = accept & (frame_w.op == OP_POWER_DOWN) & len_cmd;
  assign is_rpd    = accept & (frame_w.op == OP_RELEASE_PD);
  assign work_start = is_wrsr | is_prog | is_erase;
  assign work_done  = status_reg.busy & eng_done;
  assign sr_new     = snp_status_t'({frame_w.d2, frame_w.d1});
  assign pd_next    = ~pg_s ? 1'b0 : (is_pd ? 1'b1 : (is_rpd ? 1'b0 : pd_reg));

  always_comb begin
    status_next = status_reg;
    status_next.busy = (status_reg.busy & ~eng_done) | work_start;
    // a write enable and a completion cannot meet: busy refuses the enable
    status_next.write_permit_latch = is_wren | (wpl & ~is_wrdi & ~work_done);
    if (is_wrsr) begin
      status_next.block_protect       = sr_new.block_protect;
      status_next.bottom_select       = sr_new.bottom_select;
      status_next.small_unit_protect  = sr_new.small_unit_protect;
      status_next.status_lock_sel_low = sr_new.status_lock_sel_low;
      if (frame_w.bytes == LEN_SR_TWO) begin
        status_next.status_lock_sel_high = sr_new.status_lock_sel_high;
        status_next.four_lane_enable     = sr_new.four_lane_enable;
        status_next.complement_protect   = sr_new.complement_protect;
        // lock bits are one-time: they only ever set
        status_next.sec_reg_lock = status_reg.sec_reg_lock | sr_new.sec_reg_lock;
      end
    end
    if (!pg_s) begin
      status_next.busy = 1'b0;
      status_next.write_permit_latch = 1'b0;
      if ({status_reg.status_lock_sel_high, status_reg.status_lock_sel_low} == LOCK_POWER) begin
        status_next.status_lock_sel_high = 1'b0;
        status_next.status_lock_sel_low  = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg    <= STATUS_RESET;
      pd_reg        <= 1'b0;
      cs_prev_reg   <= 1'b1;
      pu_cnt_reg    <= PU_ZERO;
      eng_start_reg <= 1'b0;
      eng_op_reg    <= 8'h00;
    end else begin
      status_reg    <= status_next;
      pd_reg        <= pd_next;
      cs_prev_reg   <= cs_s;
      pu_cnt_reg    <= pu_cnt_next;
      eng_start_reg <= work_start | is_susp;
      eng_op_reg    <= (work_start | is_susp) ? frame_w.op : eng_op_reg;
    end
  end

  assign eng_start   = eng_start_reg;
  assign eng_op      = eng_op_reg;
  assign status_word = status_reg;
  assign prot_cfg    = '{complement_protect: status_reg.complement_protect,
                         small_unit_protect: status_reg.small_unit_protect,
                         bottom_select:      status_reg.bottom_select,
                         block_protect:      status_reg.block_protect};
endmodule // snp_serial_nor_protect
`default_nettype wire

// *** hdl/snp_sync_2ff.sv ***
// snp_sync_2ff: two flip-flop level synchroniser, one per bit.
// assumes each bit is an independent slow level; no word coherence.
`timescale 1ns/1ps
`default_nettype none
module snp_sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk) begin
    meta_reg <= d;
    sync_reg <= meta_reg;
  end

  assign q = sync_reg;
endmodule // snp_sync_2ff
`default_nettype wire

// *** verif/snp_checker_assertions.sv ***
// snp_checker: port-level assertions for the serial nor protect block.
// assumes it is bound to snp_serial_nor_protect; all sampling on core_clk.
`timescale 1ns/1ps
`default_nettype none
module snp_checker (
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire logic                 cs_n,
  input wire logic                 lane_1_oe,
  input wire logic                 lane_2_oe,
  input wire logic                 lane_3_oe,
  input wire logic                 eng_done,
  input wire logic                 eng_start,
  input wire logic [7:0]           eng_op,
  input wire snp_pkg::snp_prot_t   prot_cfg,
  input wire snp_pkg::snp_status_t status_word
);
  import snp_pkg::*;
  wire logic busy  = status_word.busy;
  wire logic latch = status_word.write_permit_latch;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_idle_float: assert property (cs_n |-> !lane_1_oe)
    else $error("driven while deselected");
  a_start_busy: assert property (eng_start |-> ##[0:1] busy)
    else $error("start without busy");
  a_done_clears: assert property (busy && eng_done |=> !busy && !latch)
    else $error("completion left busy or latch");
  a_busy_no_we: assert property ($rose(latch) |-> !$past(busy))
    else $error("latch set while busy");
  a_start_latch: assert property (eng_start && eng_op != OP_SUSPEND |-> latch)
    else $error("write started without latch");
  a_prot_follow: assert property ($stable(status_word) |-> prot_cfg == {status_word[14], status_word[6:2]})
    else $error("protection output mismatch");
  a_reset_dflt: assert property ($fell(rst) |-> status_word == STATUS_RESET && prot_cfg == '0)
    else $error("status not at defaults");
  a_quad_off: assert property (!status_word.four_lane_enable |-> !lane_2_oe && !lane_3_oe)
    else $error("quad lanes driven");
endmodule // snp_checker
`default_nettype wire

// *** verif/snp_spi_master.sv ***
// snp_spi_master: behavioural single-lane bus master, one frame per call.
// assumes the caller leaves the link idle between calls.
`timescale 1ns/1ps
`default_nettype none
module snp_spi_master (
  output logic       sclk,
  output logic       cs_n,
  output logic       lane_0_in,
  output logic       lane_3_in,
  input  wire logic  lane_1_out,
  input  wire logic  lane_1_oe,
  output logic [7:0] rx,
  output logic       rx_done,
  output logic       pause_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    lane_0_in = 1'b0;
    lane_3_in = 1'b1;
    rx_done = 1'b0;
  end
  // clock stands still between frames; released data line shows its inverse
  task automatic frame(input int nb, input logic [39:0] tx, input logic cpol, input int hold_at, input logic rd);
    sclk = cpol;
    pause_oe = 1'b0;
    #10 cs_n = 1'b0;
    for (int i = 0; i < nb * 8; i++) begin
      sclk = 1'b0;
      if (i == hold_at) begin
        #5 lane_3_in = 1'b0;
        lane_0_in = ~tx[39 - i];
        repeat (4) #24 sclk = ~sclk;
        #2 pause_oe = lane_1_oe;
        lane_3_in = 1'b1;
        #5;
      end
      lane_0_in = tx[39 - i];
      #24 sclk = 1'b1;
      rx = {rx[6:0], lane_1_out};
      #24;
    end
    sclk = cpol;
    #24 cs_n = 1'b1;
    lane_0_in = ~lane_0_in;
    rx_done = rd;
    #100 rx_done = 1'b0;
  endtask
endmodule // snp_spi_master
`default_nettype wire

// *** verif/tb_top.sv ***
// tb_top: self-checking bench; master model on the link, the bench acts as array engine.
// assumes the power-up write delay shortened to 64 core cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import snp_pkg::*;
  logic        core_clk = 1'b0, rst = 1'b1, power_good = 1'b1, lane_2_in = 1'b1, eng_done = 1'b0;
  logic [7:0]  rd_data = 8'h00, d;
  logic [31:0] lfsr = 32'h0000_83ad;
  logic [8:0]  exp_q[$];
  int          errors = 0, check_count = 0;
  wire logic   sclk, cs_n, lane_0_in, lane_3_in, lane_1_out, lane_1_oe, rx_done, pause_oe;
  wire logic [7:0] rx;
  snp_spi_master u_mst (.sclk(sclk), .cs_n(cs_n), .lane_0_in(lane_0_in), .lane_3_in(lane_3_in),
    .lane_1_out(lane_1_out), .lane_1_oe(lane_1_oe), .rx(rx), .rx_done(rx_done), .pause_oe(pause_oe));
  snp_serial_nor_protect #(.PUW_CYCLES(64)) u_dut (.core_clk(core_clk), .rst(rst), .power_good(power_good),
    .sclk(sclk), .cs_n(cs_n), .lane_0_in(lane_0_in), .lane_0_out(), .lane_0_oe(), .lane_1_in(1'b0),
    .lane_1_out(lane_1_out), .lane_1_oe(lane_1_oe), .lane_2_in(lane_2_in), .lane_2_out(), .lane_2_oe(),
    .lane_3_in(lane_3_in), .lane_3_out(), .lane_3_oe(), .rd_data(rd_data), .rd_load(), .eng_done(eng_done),
    .eng_start(), .eng_op(), .prot_cfg(), .status_word());
  initial forever #12.5 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2 lfsr = lfsr_step(lfsr);
    rd_data = lfsr[7:0];
  endtask
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: status %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge rx_done) check({pause_oe, rx}, exp_q.pop_front());
  task automatic cmd(input int nb, input logic [7:0] c, input logic [31:0] a);
    u_mst.frame(nb, {c, a}, 1'b0, -1, 1'b0);
  endtask
  task automatic rd_sr(input logic [7:0] e, input logic cpol, input int h);
    exp_q.push_back({1'b0, e});
    u_mst.frame(2, {OP_READ_STATUS_LO, 32'h0000_0000}, cpol, h, 1'b1);
  endtask
  task automatic done();
    tick(1);
    eng_done = 1'b1;
    tick(1);
    eng_done = 1'b0;
  endtask
  initial begin
    tick(5);
    rst = 1'b0;
    tick(3);
    cmd(1, OP_WRITE_ENABLE, '0);
    rd_sr(8'h00, 1'b0, -1);
    tick(70);
    cmd(1, OP_WRITE_ENABLE, '0);
    rd_sr(8'h02, 1'b1, -1);
    cmd(1, OP_WRITE_DISABLE, '0);
    rd_sr(8'h00, 1'b0, 11);
    d = lfsr[7:0] & 8'h7c;
    cmd(1, OP_WRITE_ENABLE, '0);
    cmd(2, OP_WRITE_STATUS, {d, 24'h00_0000});
    cmd(1, OP_WRITE_DISABLE, '0);
    rd_sr(d | 8'h03, 1'b0, 13);
    done();
    rd_sr(d, 1'b0, -1);
    cmd(5, OP_PAGE_PROGRAM, lfsr);
    rd_sr(d, 1'b0, -1);
    cmd(1, OP_WRITE_ENABLE, '0);
    cmd(2, OP_WRITE_STATUS, 32'h8000_0000);
    done();
    lane_2_in = 1'b0;
    cmd(1, OP_WRITE_ENABLE, '0);
    cmd(2, OP_WRITE_STATUS, 32'h1c00_0000);
    rd_sr(8'h82, 1'b0, -1);
    cmd(1, OP_POWER_DOWN, '0);
    cmd(1, OP_WRITE_DISABLE, '0);
    cmd(1, OP_RELEASE_PD, '0);
    rd_sr(8'h82, 1'b0, -1);
    cmd(5, OP_FAST_QUAD_OUT, lfsr);
    tick(20);
    finish_test();
  end
  initial begin
    #300000;
    errors++;
    finish_test();
  end
endmodule // tb_top
bind snp_serial_nor_protect snp_checker u_chk (.core_clk(core_clk), .rst(rst), .cs_n(cs_n),
  .lane_1_oe(lane_1_oe), .lane_2_oe(lane_2_oe), .lane_3_oe(lane_3_oe), .eng_done(eng_done),
  .eng_start(eng_start), .eng_op(eng_op), .prot_cfg(prot_cfg), .status_word(status_word));
`default_nettype wire
